// ==== design/codec_regs_pkg.sv ====
// Shared constants and carrier types of the codec host control registers.
// Assumes a byte-wide indirect register port already decoded to an index.
package codec_regs_pkg;

  // Widths of the register port and of the sample count.
  localparam int INDEX_W = 5;
  localparam int DATA_W  = 8;
  localparam int COUNT_W = 16;

  // Indirect indices of the registers held here.
  localparam logic [INDEX_W-1:0] IDX_DIG_MIX   = 5'h0d;
  localparam logic [INDEX_W-1:0] IDX_BASE_HIGH = 5'h0e;
  localparam logic [INDEX_W-1:0] IDX_BASE_LOW  = 5'h0f;
  localparam logic [INDEX_W-1:0] IDX_FEATURE   = 5'h10;
  localparam logic [INDEX_W-1:0] IDX_MIC_MIX   = 5'h11;
  localparam logic [INDEX_W-1:0] IDX_LEFT_LINE = 5'h12;
  localparam logic [INDEX_W-1:0] IDX_RIGHT_LINE = 5'h13;

  // Reset values; undefined bits come up as zero.
  localparam logic [DATA_W-1:0] RST_DIG_MIX   = 8'h00;
  localparam logic [DATA_W-1:0] RST_BASE      = 8'h00;
  localparam logic [DATA_W-1:0] RST_FEATURE   = 8'h11;
  localparam logic [DATA_W-1:0] RST_MIC_MIX   = 8'h10;
  localparam logic [DATA_W-1:0] RST_LINE      = 8'h88;

  // Writable bits of each register but the two base bytes, which take all eight bits; reserved bits store and read zero.
  localparam logic [DATA_W-1:0] MASK_DIG_MIX  = 8'hfd;
  localparam logic [DATA_W-1:0] MASK_FEATURE  = 8'hff;
  localparam logic [DATA_W-1:0] MASK_MIC_MIX  = 8'hfe;
  localparam logic [DATA_W-1:0] MASK_LINE     = 8'h9f;

  // Field positions.
  localparam int DIG_MIX_EN_BIT    = 0;
  localparam int DIG_ATTEN_LSB     = 2;
  localparam int UNDERRUN_ZERO_BIT = 0;
  localparam int MIC_GAIN_LSB      = 1;
  localparam int TIMER_EN_BIT      = 6;
  localparam int OUT_LEVEL_BIT     = 7;
  localparam int RIGHT_MIC_MIX_BIT = 6;
  localparam int LEFT_MIC_MIX_BIT  = 7;
  localparam int LINE_GAIN_LSB     = 0;
  localparam int LINE_MUTE_BIT     = 7;
  localparam int ATTEN_W           = 6;
  localparam int GAIN_W            = 5;

  // Gains in half-decibel units: 1.5 dB per code, +12 dB at code zero.
  localparam logic signed [7:0] HALF_DB_PER_STEP = 8'sh03;
  localparam logic signed [7:0] GAIN_TOP_HALF_DB = 8'sh18;

  // One register port request, valid for one cycle.
  typedef struct packed {
    logic               wr;
    logic               rd;
    logic [INDEX_W-1:0] index;
    logic [DATA_W-1:0]  wdata;
  } reg_req_t;

  // Decoded mixer and converter controls.
  typedef struct packed {
    logic              dig_mix_en;
    logic [7:0]        dig_atten_half_db;
    logic signed [7:0] left_mic_half_db;
    logic signed [7:0] right_mic_half_db;
    logic signed [7:0] left_line_half_db;
    logic signed [7:0] right_line_half_db;
    logic              left_mic_mix_en;
    logic              right_mic_mix_en;
    logic              left_line_mute;
    logic              right_line_mute;
    logic              output_level_select;
  } mix_ctrl_t;

endpackage

// ==== design/sample_down_counter.sv ====
// Reloadable down counter that flags the step past zero.
// Assumes load and step are one-cycle pulses in the i_clk domain.
`timescale 1ns/1ps
module sample_down_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_base,
  input  wire logic             i_step,
  output logic                  o_underflow
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             underflow_q;
  logic             underflow_d;

  // A load wins over a step; a step at zero reloads and flags underflow.
  always_comb
  begin
    count_d     = count_q;
    underflow_d = 1'b0;
    if (i_load)
    begin
      count_d = i_base;
    end
    else if (i_step)
    begin
      if (count_q == '0)
      begin
        count_d     = i_base;
        underflow_d = 1'b1;
      end
      else
      begin
        count_d = count_q - WIDTH'(1);
      end
    end
  end

  // Counter state registers.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count_q     <= '0;
      underflow_q <= 1'b0;
    end
    else
    begin
      count_q     <= count_d;
      underflow_q <= underflow_d;
    end
  end

  assign o_underflow = underflow_q;

endmodule

// ==== design/sample_count_irq_and_mix_regs.sv ====
// Indirect control registers: sample count interrupt, timer enable, mix gains.
// Assumes the host port is decoded to single-cycle index requests on i_clk,
// and that sample, transfer and timer ticks are single-cycle pulses.
`timescale 1ns/1ps
module sample_count_irq_and_mix_regs #(
  parameter int COUNT_W = codec_regs_pkg::COUNT_W
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire codec_regs_pkg::reg_req_t      i_req,
  input  wire logic                          i_status_wr,
  input  wire logic                          i_expanded_mode,
  input  wire logic                          i_playback_enable_bit,
  input  wire logic                          i_capture_enable_bit,
  input  wire logic                          i_irq_pin_enable,
  input  wire logic                          i_sample_tick,
  input  wire logic                          i_playback_xfer,
  input  wire logic                          i_playback_underrun,
  input  wire logic [COUNT_W-1:0]            i_timer_period,
  input  wire logic                          i_timer_tick,
  output logic [codec_regs_pkg::DATA_W-1:0]  o_rdata,
  output logic                               o_rvalid,
  output logic                               o_irq,
  output logic                               o_count_irq_pending,
  output logic                               o_timer_irq_flag,
  output logic                               o_dac_midscale,
  output logic                               o_dac_repeat,
  output codec_regs_pkg::mix_ctrl_t          o_mix
);
  import codec_regs_pkg::*;

  // Stored register images.
  logic [DATA_W-1:0] dig_mix_q,    dig_mix_d;
  logic [DATA_W-1:0] base_high_q,  base_high_d;
  logic [DATA_W-1:0] base_low_q,   base_low_d;
  logic [DATA_W-1:0] feature_q,    feature_d;
  logic [DATA_W-1:0] mic_mix_q,    mic_mix_d;
  logic [DATA_W-1:0] left_line_q,  left_line_d;
  logic [DATA_W-1:0] right_line_q, right_line_d;

  // Read port, interrupt and underrun state.
  logic [DATA_W-1:0] rdata_q,      rdata_d;
  logic              rvalid_q,     rvalid_d;
  logic              count_pend_q, count_pend_d;
  logic              timer_flag_q, timer_flag_d;
  logic              irq_q,        irq_d;
  logic              midscale_q,   midscale_d;
  logic              repeat_q,     repeat_d;

  // Timer state.
  logic [COUNT_W-1:0] timer_cnt_q, timer_cnt_d;
  logic               timer_en_q,  timer_en_d;

  // Decoded mixer controls.
  mix_ctrl_t mix_q, mix_d;

  // Request decode and counter hookup.
  logic        expanded_access;
  logic        wr_high;
  logic        count_step;
  logic        count_underflow;
  logic [COUNT_W-1:0] load_base;
  logic        timer_en_now;
  logic        timer_expire;

  // Maps a 1.5 dB step gain code to half-decibel units from +12 dB.
  function automatic logic signed [7:0] gain_half_db(input logic [GAIN_W-1:0] code);
    logic signed [7:0] steps;
    steps = $signed({3'b000, code});
    gain_half_db = 8'(GAIN_TOP_HALF_DB - steps * HALF_DB_PER_STEP);
  endfunction

  // True when the index is an expanded-mode register.
  function automatic logic is_expanded_index(input logic [INDEX_W-1:0] idx);
    is_expanded_index = (idx >= IDX_FEATURE) && (idx <= IDX_RIGHT_LINE);
  endfunction

  // Expanded registers only answer while expanded mode is on.
  assign expanded_access = i_expanded_mode || !is_expanded_index(i_req.index);
  assign wr_high         = i_req.wr && (i_req.index == IDX_BASE_HIGH);

  // Compat mode counts sample periods; expanded mode counts playback transfers.
  assign count_step = i_expanded_mode ? (i_playback_xfer && i_playback_enable_bit)
                                      : (i_sample_tick &&
                                         (i_playback_enable_bit || i_capture_enable_bit));

  // A high byte write loads the new pair; an underflow reloads the stored pair, not the bus data.
  assign load_base = wr_high ? {i_req.wdata, base_low_q} : {base_high_q, base_low_q};

  // Down counter for the sample base count.
  sample_down_counter #(
    .WIDTH (COUNT_W)
  ) u_count (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_load      (wr_high),
    .i_base      (load_base),
    .i_step      (count_step),
    .o_underflow (count_underflow)
  );

  // Register writes; reserved bits are masked away.
  always_comb
  begin
    dig_mix_d    = dig_mix_q;
    base_high_d  = base_high_q;
    base_low_d   = base_low_q;
    feature_d    = feature_q;
    mic_mix_d    = mic_mix_q;
    left_line_d  = left_line_q;
    right_line_d = right_line_q;
    if (i_req.wr && expanded_access)
    begin
      unique case (i_req.index)
        IDX_DIG_MIX:    dig_mix_d    = i_req.wdata & MASK_DIG_MIX;
        IDX_BASE_HIGH:  base_high_d  = i_req.wdata;
        IDX_BASE_LOW:   base_low_d   = i_req.wdata;
        IDX_FEATURE:    feature_d    = i_req.wdata & MASK_FEATURE;
        IDX_MIC_MIX:    mic_mix_d    = i_req.wdata & MASK_MIC_MIX;
        IDX_LEFT_LINE:  left_line_d  = i_req.wdata & MASK_LINE;
        IDX_RIGHT_LINE: right_line_d = i_req.wdata & MASK_LINE;
        default:        dig_mix_d    = dig_mix_q;
      endcase
    end
  end

  // Register image flip-flops.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dig_mix_q    <= RST_DIG_MIX;
      base_high_q  <= RST_BASE;
      base_low_q   <= RST_BASE;
      feature_q    <= RST_FEATURE;
      mic_mix_q    <= RST_MIC_MIX;
      left_line_q  <= RST_LINE;
      right_line_q <= RST_LINE;
    end
    else
    begin
      dig_mix_q    <= dig_mix_d;
      base_high_q  <= base_high_d;
      base_low_q   <= base_low_d;
      feature_q    <= feature_d;
      mic_mix_q    <= mic_mix_d;
      left_line_q  <= left_line_d;
      right_line_q <= right_line_d;
    end
  end

  // Read data: base bytes return the written value, never the running count.
  always_comb
  begin
    rdata_d  = '0;
    rvalid_d = i_req.rd;
    if (i_req.rd && expanded_access)
    begin
      unique case (i_req.index)
        IDX_DIG_MIX:    rdata_d = dig_mix_q;
        IDX_BASE_HIGH:  rdata_d = base_high_q;
        IDX_BASE_LOW:   rdata_d = base_low_q;
        IDX_FEATURE:    rdata_d = feature_q;
        IDX_MIC_MIX:    rdata_d = mic_mix_q;
        IDX_LEFT_LINE:  rdata_d = left_line_q;
        IDX_RIGHT_LINE: rdata_d = right_line_q;
        default:        rdata_d = '0;
      endcase
    end
  end

  // Read port flip-flops.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // The timer runs from the enable bit that is about to be stored.
  assign timer_en_now = feature_d[TIMER_EN_BIT];
  assign timer_expire = timer_en_q && i_timer_tick && (timer_cnt_q == '0);

  // Timer: enabling reloads the period, each expiry reloads and flags.
  always_comb
  begin
    timer_en_d  = timer_en_now;
    timer_cnt_d = timer_cnt_q;
    if (timer_en_now && !timer_en_q)
    begin
      timer_cnt_d = i_timer_period;
    end
    else if (timer_en_q && timer_en_now && i_timer_tick)
    begin
      if (timer_cnt_q == '0)
      begin
        timer_cnt_d = i_timer_period;
      end
      else
      begin
        timer_cnt_d = timer_cnt_q - COUNT_W'(1);
      end
    end
  end

  // Timer flip-flops.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      timer_en_q  <= 1'b0;
      timer_cnt_q <= '0;
    end
    else
    begin
      timer_en_q  <= timer_en_d;
      timer_cnt_q <= timer_cnt_d;
    end
  end

  // Interrupt sources: a new event beats a simultaneous status clear,
  // but turning the timer off clears its flag at once.
  always_comb
  begin
    count_pend_d = count_pend_q;
    if (i_status_wr)
    begin
      count_pend_d = 1'b0;
    end
    if (count_underflow)
    begin
      count_pend_d = 1'b1;
    end
    timer_flag_d = timer_flag_q;
    if (i_status_wr)
    begin
      timer_flag_d = 1'b0;
    end
    if (timer_expire)
    begin
      timer_flag_d = 1'b1;
    end
    if (!timer_en_now)
    begin
      timer_flag_d = 1'b0;
    end
    irq_d = i_irq_pin_enable && (count_pend_d || timer_flag_d);
  end

  // Interrupt flip-flops.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      count_pend_q <= 1'b0;
      timer_flag_q <= 1'b0;
      irq_q        <= 1'b0;
    end
    else
    begin
      count_pend_q <= count_pend_d;
      timer_flag_q <= timer_flag_d;
      irq_q        <= irq_d;
    end
  end

  // Underrun response; compat mode always outputs midscale.
  always_comb
  begin
    midscale_d = i_playback_underrun &&
                 (!i_expanded_mode || feature_q[UNDERRUN_ZERO_BIT]);
    repeat_d   = i_playback_underrun && i_expanded_mode &&
                 !feature_q[UNDERRUN_ZERO_BIT];
  end

  // Underrun flip-flops.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      midscale_q <= 1'b0;
      repeat_q   <= 1'b0;
    end
    else
    begin
      midscale_q <= midscale_d;
      repeat_q   <= repeat_d;
    end
  end

  // Decode gains, attenuation, mutes and routing for the analog side.
  always_comb
  begin
    mix_d.dig_mix_en          = dig_mix_q[DIG_MIX_EN_BIT];
    mix_d.dig_atten_half_db   = 8'({2'b00, dig_mix_q[DIG_ATTEN_LSB +: ATTEN_W]} *
                                   8'(HALF_DB_PER_STEP));
    mix_d.left_mic_half_db    = gain_half_db(feature_q[MIC_GAIN_LSB +: GAIN_W]);
    mix_d.right_mic_half_db   = gain_half_db(mic_mix_q[MIC_GAIN_LSB +: GAIN_W]);
    mix_d.left_line_half_db   = gain_half_db(left_line_q[LINE_GAIN_LSB +: GAIN_W]);
    mix_d.right_line_half_db  = gain_half_db(right_line_q[LINE_GAIN_LSB +: GAIN_W]);
    mix_d.left_mic_mix_en     = mic_mix_q[LEFT_MIC_MIX_BIT];
    mix_d.right_mic_mix_en    = mic_mix_q[RIGHT_MIC_MIX_BIT];
    mix_d.left_line_mute      = left_line_q[LINE_MUTE_BIT];
    mix_d.right_line_mute     = right_line_q[LINE_MUTE_BIT];
    mix_d.output_level_select = feature_q[OUT_LEVEL_BIT];
  end

  // Mixer control flip-flops; reset matches the decoded register resets.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mix_q <= '{dig_mix_en: 1'b0, dig_atten_half_db: 8'h00,
                 left_mic_half_db: 8'sh00, right_mic_half_db: 8'sh00,
                 left_line_half_db: 8'sh00, right_line_half_db: 8'sh00,
                 left_mic_mix_en: 1'b0, right_mic_mix_en: 1'b0,
                 left_line_mute: 1'b1, right_line_mute: 1'b1,
                 output_level_select: 1'b0};
    end
    else
    begin
      mix_q <= mix_d;
    end
  end

  // Outputs straight from flip-flops.
  assign o_rdata             = rdata_q;
  assign o_rvalid            = rvalid_q;
  assign o_irq               = irq_q;
  assign o_count_irq_pending = count_pend_q;
  assign o_timer_irq_flag    = timer_flag_q;
  assign o_dac_midscale      = midscale_q;
  assign o_dac_repeat        = repeat_q;
  assign o_mix               = mix_q;

endmodule

// ==== dv/sample_count_irq_and_mix_regs_checker.sv ====
// Port-level checker for the codec control register block.
// Assumes one clock domain with an active-high asynchronous reset.
`timescale 1ns/1ps
module sample_count_irq_and_mix_regs_checker
  import codec_regs_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic                      i_clk,
  input wire logic                      i_rst,
  input wire codec_regs_pkg::reg_req_t  i_req,
  input wire logic                      i_status_wr,
  input wire logic                      i_expanded_mode,
  input wire logic                      i_irq_pin_enable,
  input wire logic                      i_sample_tick,
  input wire logic                      i_playback_xfer,
  input wire logic [DATA_W-1:0]         o_rdata,
  input wire logic                      o_rvalid,
  input wire logic                      o_irq,
  input wire logic                      o_count_irq_pending,
  input wire logic                      o_timer_irq_flag,
  input wire codec_regs_pkg::mix_ctrl_t o_mix
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // A step just before a status write may legally set the flag again, so those cases are left out.
  logic step;
  logic ewr;
  assign step = i_sample_tick | i_playback_xfer;
  assign ewr  = i_req.wr & i_expanded_mode;

  AST_RVALID: assert property (o_rvalid == $past(i_req.rd))
    else $error("Read valid is not one cycle after its request.");
  AST_REFUSED: assert property (
    i_req.rd && !i_expanded_mode && i_req.index[4:2] == 3'b100 |=> o_rdata == 8'h00)
    else $error("Expanded register readable in compatibility mode.");
  AST_IRQ: assert property (
    o_irq == ($past(i_irq_pin_enable) && (o_count_irq_pending || o_timer_irq_flag)))
    else $error("Interrupt output does not match its sources.");
  AST_STATUS: assert property (
    i_status_wr && !step && !$past(step) && !$past(step, 2) |=> !o_count_irq_pending)
    else $error("Status write did not clear the count interrupt.");
  AST_TIMER_OFF: assert property (
    ewr && i_req.index == IDX_FEATURE && !i_req.wdata[TIMER_EN_BIT] |=> !o_timer_irq_flag)
    else $error("Timer flag survived clearing the timer enable.");
  AST_MIC_GAIN: assert property (
    ewr && i_req.index == IDX_FEATURE
    |-> ##2 o_mix.left_mic_half_db == 8'(24 - 3 * $past(i_req.wdata[5:1], 2)))
    else $error("Left mic gain decode wrong.");
  AST_LINE: assert property (
    ewr && i_req.index == IDX_LEFT_LINE
    |-> ##2 o_mix.left_line_half_db == 8'(24 - 3 * $past(i_req.wdata[4:0], 2))
    && o_mix.left_line_mute == $past(i_req.wdata[7], 2))
    else $error("Left line gain or mute decode wrong.");
  AST_ATTEN: assert property (
    i_req.wr && i_req.index == IDX_DIG_MIX
    |-> ##2 o_mix.dig_atten_half_db == 8'(3 * $past(i_req.wdata[7:2], 2)))
    else $error("Digital mix attenuation decode wrong.");

  // Main scenarios that the bench should reach.
  COV_COUNT: cover property ($rose(o_count_irq_pending));
  COV_TIMER: cover property ($rose(o_timer_irq_flag));
  COV_REFUSED: cover property (i_req.rd && !i_expanded_mode && i_req.index == IDX_FEATURE);
endmodule

bind sample_count_irq_and_mix_regs sample_count_irq_and_mix_regs_checker #(.COUNT_W(COUNT_W)) u_checker (
  .i_clk, .i_rst, .i_req, .i_status_wr, .i_expanded_mode, .i_irq_pin_enable, .i_sample_tick,
  .i_playback_xfer, .o_rdata, .o_rvalid, .o_irq, .o_count_irq_pending, .o_timer_irq_flag, .o_mix
);

// ==== dv/dma_sample_source.sv ====
// Behavioural sample clock and DMA controller feeding the count logic.
// Assumes bursts are started from one procedural thread at a time.
`timescale 1ns/1ps
module dma_sample_source (
  input  wire logic i_clk,
  output logic      o_sample_tick,
  output logic      o_playback_xfer
);
  // Idle until a burst is asked for.
  initial
  begin
    o_sample_tick   = 1'b0;
    o_playback_xfer = 1'b0;
  end

  // Sends n sample periods, gap plus one idle cycles apart; xfer marks a real playback transfer.
  task automatic burst(input int n, input int gap, input bit xfer);
    for (int i = 0; i < n; i++)
    begin
      @(negedge i_clk);
      o_sample_tick   <= 1'b1;
      o_playback_xfer <= xfer;
      @(negedge i_clk);
      o_sample_tick   <= 1'b0;
      o_playback_xfer <= 1'b0;
      repeat (gap) @(negedge i_clk);
    end
  endtask
endmodule

// ==== dv/sample_count_irq_and_mix_regs_tb_top.sv ====
// Self-checking bench for the codec control register block.
// Assumes the package, the design, the checker and the sample source are compiled first.
`timescale 1ns/1ps
module sample_count_irq_and_mix_regs_tb_top;
  import codec_regs_pkg::*;

  localparam logic [4:0] IDX [7] = '{IDX_DIG_MIX, IDX_BASE_HIGH, IDX_BASE_LOW, IDX_FEATURE,
                                     IDX_MIC_MIX, IDX_LEFT_LINE, IDX_RIGHT_LINE};
  localparam logic [7:0] MSK [7] = '{MASK_DIG_MIX, 8'hff, 8'hff, MASK_FEATURE, MASK_MIC_MIX, MASK_LINE, MASK_LINE};
  localparam logic [7:0] RST [7] = '{RST_DIG_MIX, RST_BASE, RST_BASE, RST_FEATURE, RST_MIC_MIX, RST_LINE, RST_LINE};

  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  reg_req_t    req = '0;
  logic        status_wr = 1'b0, exp_mode = 1'b0, playback_enable_bit = 1'b0, capture_enable_bit = 1'b0, pin_en = 1'b0;
  logic        underrun = 1'b0, timer_tick = 1'b0;
  logic [15:0] timer_period = 16'h0003;
  logic        sample_tick, xfer, rvalid, irq, pending, tflag, midscale, dac_rep;
  logic [7:0]  rdata;
  mix_ctrl_t   mix;
  logic [7:0]  shadow [7];
  logic [7:0]  exp_q [$];
  int          n_fail = 0;
  int          n_checks = 0;

  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end

  sample_count_irq_and_mix_regs u_sample_count_irq_and_mix_regs (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_status_wr(status_wr), .i_expanded_mode(exp_mode),
    .i_playback_enable_bit(playback_enable_bit), .i_capture_enable_bit(capture_enable_bit), .i_irq_pin_enable(pin_en),
    .i_sample_tick(sample_tick), .i_playback_xfer(xfer), .i_playback_underrun(underrun),
    .i_timer_period(timer_period), .i_timer_tick(timer_tick), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_irq(irq), .o_count_irq_pending(pending), .o_timer_irq_flag(tflag), .o_dac_midscale(midscale),
    .o_dac_repeat(dac_rep), .o_mix(mix)
  );

  dma_sample_source u_dma_sample_source (
    .i_clk(i_clk), .o_sample_tick(sample_tick), .o_playback_xfer(xfer)
  );

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    n_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // One register request held for one cycle, then one idle cycle.
  task automatic op(input logic w, input logic r, input logic [4:0] idx, input logic [7:0] d);
    @(negedge i_clk);
    req <= '{w, r, idx, d};
    @(negedge i_clk);
    req <= '0;
  endtask

  // Notes the expected read data, then issues the read.
  task automatic rd(input logic [4:0] idx, input logic [7:0] want);
    exp_q.push_back(want);
    op(1'b0, 1'b1, idx, 8'h00);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic tick_timer(input int n);
    repeat (n)
    begin
      @(negedge i_clk);
      timer_tick <= 1'b1;
      @(negedge i_clk);
      timer_tick <= 1'b0;
    end
  endtask

  // Gain code to half-decibel units: +12 dB at code zero, 1.5 dB down per code.
  function automatic logic signed [7:0] half_db(input logic [4:0] c);
    return 8'(24 - 3 * c);
  endfunction

  // Compares the decoded mixer controls with the stored register images.
  task automatic check_mix();
    mix_ctrl_t m;
    m.dig_mix_en          = shadow[0][0];
    m.dig_atten_half_db   = 8'(3 * shadow[0][7:2]);
    m.left_mic_half_db    = half_db(shadow[3][5:1]);
    m.right_mic_half_db   = half_db(shadow[4][5:1]);
    m.left_line_half_db   = half_db(shadow[5][4:0]);
    m.right_line_half_db  = half_db(shadow[6][4:0]);
    m.left_mic_mix_en     = shadow[4][7];
    m.right_mic_mix_en    = shadow[4][6];
    m.left_line_mute      = shadow[5][7];
    m.right_line_mute     = shadow[6][7];
    m.output_level_select = shadow[3][7];
    check(mix, m);
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Takes the oldest noted read result whenever read data appears.
  always @(negedge i_clk)
  begin
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(1, 0);
      else
        check(rdata, exp_q.pop_front());
    end
  end

  // Cuts a hang short.
  initial
  begin
    repeat (30000) @(posedge i_clk);
    n_fail++;
    conclude();
  end

  initial
  begin
    int         lo;
    logic [7:0] d;
    void'($urandom(32'h069a));
    wait_cyc(5);
    i_rst = 1'b0;
    shadow = RST;
    wait_cyc(2);
    check_mix();
    for (int i = 0; i < 7; i++)
      rd(IDX[i], (i < 3) ? RST[i] : 8'h00);
    exp_mode = 1'b1;
    rd(5'h1f, 8'h00);
    for (int i = 0; i < 7; i++)
      rd(IDX[i], RST[i]);
    // Random images, read back and decoded; a compatibility-mode write must be dropped.
    for (int r = 0; r < 3; r++)
    begin
      for (int i = 0; i < 7; i++)
      begin
        d = 8'($urandom);
        shadow[i] = d & MSK[i];
        op(1'b1, 1'b0, IDX[i], d);
        rd(IDX[i], shadow[i]);
      end
      wait_cyc(2);
      check_mix();
      exp_mode = 1'b0;
      op(1'b1, 1'b0, IDX[3 + r], ~shadow[3 + r]);
      exp_mode = 1'b1;
      rd(IDX[3 + r], shadow[3 + r]);
    end
    // Sample count: compatibility mode on capture, then expanded mode on playback transfers.
    for (int m = 0; m < 2; m++)
    begin
      lo = $urandom_range(7);
      exp_mode = (m == 1);
      capture_enable_bit = (m == 0);
      playback_enable_bit = (m == 1);
      op(1'b1, 1'b0, IDX_BASE_LOW, 8'(lo));
      op(1'b1, 1'b0, IDX_BASE_HIGH, 8'h01);
      if (m == 1)
        u_dma_sample_source.burst(20, 0, 1'b0);
      for (int k = 0; k < 2; k++)
      begin
        pin_en = (k == 0);
        u_dma_sample_source.burst(256 + lo, m, 1'b1);
        wait_cyc(4);
        check({pending, irq}, 2'b00);
        u_dma_sample_source.burst(1, 0, 1'b1);
        wait_cyc(4);
        check(pending, 1'b1);
        check(irq, pin_en);
        @(negedge i_clk) status_wr <= 1'b1;
        @(negedge i_clk) status_wr <= 1'b0;
        wait_cyc(2);
        check({pending, irq}, 2'b00);
      end
      rd(IDX_BASE_LOW, 8'(lo));
      op(1'b1, 1'b0, IDX_BASE_HIGH, 8'hff);
    end
    {capture_enable_bit, playback_enable_bit} = 2'b00;
    // Timer: enable reloads the period, the tick past zero flags, disable clears at once.
    exp_mode = 1'b1;
    pin_en = 1'b1;
    timer_period = 16'($urandom_range(5, 2));
    op(1'b1, 1'b0, IDX_FEATURE, 8'h00);
    op(1'b1, 1'b0, IDX_FEATURE, 8'h40);
    tick_timer(int'(timer_period));
    wait_cyc(3);
    check(tflag, 1'b0);
    tick_timer(1);
    wait_cyc(3);
    check({tflag, irq}, 2'b11);
    op(1'b1, 1'b0, IDX_FEATURE, 8'h00);
    check({tflag, irq}, 2'b00);
    // Underrun: zero select gives midscale, else repeat; compatibility mode is always midscale.
    op(1'b1, 1'b0, IDX_FEATURE, 8'h01);
    underrun = 1'b1;
    wait_cyc(3);
    check({midscale, dac_rep}, 2'b10);
    op(1'b1, 1'b0, IDX_FEATURE, 8'h00);
    wait_cyc(3);
    check({midscale, dac_rep}, 2'b01);
    exp_mode = 1'b0;
    wait_cyc(3);
    check({midscale, dac_rep}, 2'b10);
    underrun = 1'b0;
    wait_cyc(4);
    check(exp_q.size(), 0);
    conclude();
  end
endmodule
